// ---- design/wdt_timer.v ----
// Behaviour
// - timer disabled holds the counter at zero and stops it.
// - timer enabled counts on each selected prescaler tick and allows interrupts.
// - interval mode requests an interval interrupt on each overflow, no reset.
// - watchdog mode generates an internal reset on counter overflow.
// - clock select picks clk/2,32,64,128,256,512,2048,4096 for codes 0 to 7.
// - overflow flag sets when the counter wraps from FF to 00.
// - overflow flag clears by reading it as 1 then writing 0; 1 is ignored.
// - a watchdog reset sets the watchdog reset flag in bit 7.
// - watchdog reset flag clears by read-as-1 then write 0; writes of 1 ignored.
// - reset pin drive enable gates the reset onto the pin; defaults off.
`timescale 1ns/100ps
`include "wdt_regs.vh"
module wdt_timer #(
  parameter PRE_WIDTH = 12
) (
  // clock and reset
  input  wire        sys_clk_i,
  input  wire        resetn_i,
  // apb slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  input  wire [3:0]  pstrb_i,
  output reg  [31:0] prdata_o,
  output reg         pready_o,
  output reg         pslverr_o,
  // events
  output reg         irq_o,
  output reg         wd_reset_o,
  output reg         reset_pin_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // registers
  reg        overflow_flag_q;
  reg        watchdog_or_interval_select_q;
  reg        timer_run_enable_q;
  reg  [2:0] clock_divider_sel_q;
  reg  [7:0] wd_count_q;
  reg  [7:0] wd_count_d;
  reg        watchdog_reset_flag_q;
  reg        reset_pin_drive_enable_q;
  reg        ovf_seen_q;
  reg        watchdog_reset_flag_seen_q;
  reg  [1:0] int_stat_q;
  reg  [1:0] int_mask_q;
  reg        fire_q;

  wire       tick;
  wire       pulse_active;
  wire       overflow;
  wire       apb_access;
  wire       wr;
  wire       rd;
  wire [7:0] idx;
  wire [7:0] key;
  wire [7:0] wbyte;
  wire       addr_ok;
  wire       cnt_wr;

  function [7:0] word_index;
    input [11:0] a;
    begin
      word_index = a[9:2];
    end
  endfunction

  assign apb_access = psel_i & penable_i & pready_o;
  assign wr         = apb_access & pwrite_i & (&pstrb_i[1:0]);
  assign rd         = apb_access & ~pwrite_i;
  assign idx        = word_index(paddr_i);
  assign key        = pwdata_i[15:8];
  assign wbyte      = pwdata_i[7:0];
  assign addr_ok    = (paddr_i[1:0] == 2'h0) && (paddr_i[11:10] == 2'h0) &&
                      ((idx == `WDT_IDX_CTRL_STAT) || (idx == `WDT_IDX_COUNT_RD) ||
                       (idx == `WDT_IDX_RST_CTRL_STAT) || (idx == `WDT_IDX_RST_WR) ||
                       (idx == `WDT_IDX_INT_STAT) || (idx == `WDT_IDX_INT_MASK));

  ////////////////////////////////////////////////////////////////////////////////
  // prescaler and reset pulse
  wdt_prescaler #(
    .WIDTH (PRE_WIDTH)
  ) u_pre (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .sel_i     (clock_divider_sel_q),
    .tick_o    (tick)
  );

  wdt_reset_pulse u_pulse (
    .sys_clk_i (sys_clk_i),
    .resetn_i  (resetn_i),
    .fire_i    (fire_q),
    .active_o  (pulse_active)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // counter
  assign cnt_wr   = wr && (idx == `WDT_IDX_CTRL_STAT) && (key == `WDT_KEY_CNT);
  // a write that lands on a tick replaces the count, so it is no wrap
  assign overflow = timer_run_enable_q & tick & ~cnt_wr & (wd_count_q == 8'hFF);

  // a counter write wins over a tick in the same cycle
  always @*
  begin
    wd_count_d = wd_count_q;
    if (!timer_run_enable_q)
      wd_count_d = 8'h00;
    else if (cnt_wr)
      wd_count_d = wbyte;
    else if (tick)
      wd_count_d = wd_count_q + 8'h01;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register writes and flags
  always @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      wd_count_q                    <= 8'h00;
      overflow_flag_q               <= 1'b0;
      watchdog_or_interval_select_q <= 1'b0;
      timer_run_enable_q            <= 1'b0;
      clock_divider_sel_q           <= 3'h0;
      watchdog_reset_flag_q         <= 1'b0;
      reset_pin_drive_enable_q      <= 1'b0;
      ovf_seen_q                    <= 1'b0;
      watchdog_reset_flag_seen_q                   <= 1'b0;
      int_stat_q                    <= 2'h0;
      int_mask_q                    <= 2'h0;
      fire_q                        <= 1'b0;
    end
    else
    begin
      wd_count_q <= wd_count_d;
      fire_q     <= overflow & watchdog_or_interval_select_q;

      // read of a set flag arms the clear
      if (rd && idx == `WDT_IDX_CTRL_STAT && overflow_flag_q)
        ovf_seen_q <= 1'b1;
      if (rd && idx == `WDT_IDX_RST_CTRL_STAT && watchdog_reset_flag_q)
        watchdog_reset_flag_seen_q <= 1'b1;

      if (wr && idx == `WDT_IDX_CTRL_STAT && key == `WDT_KEY_CS)
      begin
        watchdog_or_interval_select_q <= wbyte[`WDT_CS_MODE_BIT];
        timer_run_enable_q            <= wbyte[`WDT_CS_RUN_BIT];
        clock_divider_sel_q           <= wbyte[2:0];
        if (!wbyte[`WDT_CS_OVF_BIT] && ovf_seen_q)
        begin
          overflow_flag_q <= 1'b0;
          ovf_seen_q      <= 1'b0;
        end
      end
      if (wr && idx == `WDT_IDX_RST_WR && key == `WDT_KEY_RST_OE)
        reset_pin_drive_enable_q <= wbyte[`WDT_RCS_OE_BIT];
      if (wr && idx == `WDT_IDX_RST_WR && key == `WDT_KEY_RST_FLAG &&
          !wbyte[`WDT_RCS_FLAG_BIT] && watchdog_reset_flag_seen_q)
      begin
        watchdog_reset_flag_q <= 1'b0;
        watchdog_reset_flag_seen_q           <= 1'b0;
      end
      if (wr && idx == `WDT_IDX_INT_MASK)
        int_mask_q <= wbyte[1:0];

      // reading interrupt status clears it; a new event in that cycle wins
      if (rd && idx == `WDT_IDX_INT_STAT)
        int_stat_q <= 2'h0;

      // hardware sets win over software clears
      if (overflow)
      begin
        overflow_flag_q <= 1'b1;
        if (!watchdog_or_interval_select_q)
          int_stat_q[`WDT_IRQ_INTERVAL_BIT] <= 1'b1;
        else
        begin
          watchdog_reset_flag_q <= 1'b1;
          int_stat_q[`WDT_IRQ_WATCHDOG_BIT] <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // outputs
  always @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      irq_o       <= 1'b0;
      wd_reset_o  <= 1'b0;
      reset_pin_o <= 1'b0;
    end
    else
    begin
      // interrupts only pass while the timer runs
      irq_o       <= timer_run_enable_q & |(int_stat_q & int_mask_q);
      wd_reset_o  <= pulse_active;
      reset_pin_o <= pulse_active & reset_pin_drive_enable_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state, answer on the second access cycle
  always @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end
    else if (psel_i && penable_i && !pready_o)
    begin
      pready_o  <= 1'b1;
      pslverr_o <= ~addr_ok;
      prdata_o  <= 32'h0000_0000;
      if (!pwrite_i)
      begin
        if (idx == `WDT_IDX_CTRL_STAT)
          prdata_o[7:0] <= {overflow_flag_q, watchdog_or_interval_select_q, timer_run_enable_q,
                            2'b11, clock_divider_sel_q};
        else if (idx == `WDT_IDX_COUNT_RD)
          prdata_o[7:0] <= wd_count_q;
        else if (idx == `WDT_IDX_RST_CTRL_STAT)
          prdata_o[7:0] <= {watchdog_reset_flag_q, reset_pin_drive_enable_q, 6'h3F};
        else if (idx == `WDT_IDX_INT_STAT)
          prdata_o[7:0] <= {6'h00, int_stat_q};
        else if (idx == `WDT_IDX_INT_MASK)
          prdata_o[7:0] <= {6'h00, int_mask_q};
      end
    end
    else
    begin
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
  end
endmodule

// ---- design/wdt_regs.vh ----
`ifndef WDT_REGS_VH
`define WDT_REGS_VH
// register indices (printed offsets); byte address is four times the index
`define WDT_IDX_CTRL_STAT      8'hA8
`define WDT_IDX_COUNT_RD       8'hA9
`define WDT_IDX_RST_CTRL_STAT  8'hAB
`define WDT_IDX_RST_WR         8'hAA
`define WDT_IDX_INT_STAT       8'hB8
`define WDT_IDX_INT_MASK       8'hB9
// control/status fields
`define WDT_CS_OVF_BIT         7
`define WDT_CS_MODE_BIT        6
`define WDT_CS_RUN_BIT         5
`define WDT_CS_RESET_VAL       8'h18
`define WDT_CS_RSVD_MASK       8'h18
// reset control/status fields
`define WDT_RCS_FLAG_BIT       7
`define WDT_RCS_OE_BIT         6
`define WDT_RCS_RSVD_MASK      8'h3F
// write keys in bits 15:8 of the write data
`define WDT_KEY_CS             8'hA5
`define WDT_KEY_CNT            8'h5A
`define WDT_KEY_RST_FLAG       8'hA5
`define WDT_KEY_RST_OE         8'h5A
// interrupt status bits
`define WDT_IRQ_INTERVAL_BIT   0
`define WDT_IRQ_WATCHDOG_BIT   1
// reset pulse length in system clocks
`define WDT_RESET_PULSE_CYC    8'h10
`endif

// ---- design/wdt_prescaler.v ----
`timescale 1ns/100ps
`include "wdt_regs.vh"
module wdt_prescaler #(
  parameter WIDTH = 12
) (
  // clock and reset
  input  wire       sys_clk_i,
  input  wire       resetn_i,
  // tap select
  input  wire [2:0] sel_i,
  output reg        tick_o
);
  reg  [WIDTH-1:0] div_q;
  wire [WIDTH-1:0] div_d;
  reg  [WIDTH-1:0] prev_q;
  reg  [3:0]       tap;

  assign div_d = div_q + {{(WIDTH-1){1'b0}}, 1'b1};

  // tap bit index: falling edge of bit n gives clk/2^(n+1)
  always @*
  begin
    case (sel_i)
      3'h0:    tap = 4'h0;
      3'h1:    tap = 4'h4;
      3'h2:    tap = 4'h5;
      3'h3:    tap = 4'h6;
      3'h4:    tap = 4'h7;
      3'h5:    tap = 4'h8;
      3'h6:    tap = 4'hA;
      default: tap = 4'hB;
    endcase
  end

  always @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      div_q  <= {WIDTH{1'b0}};
      prev_q <= {WIDTH{1'b0}};
      tick_o <= 1'b0;
    end
    else
    begin
      div_q  <= div_d;
      prev_q <= div_q;
      tick_o <= prev_q[tap] & ~div_q[tap];
    end
  end
endmodule

// ---- design/wdt_reset_pulse.v ----
`timescale 1ns/100ps
`include "wdt_regs.vh"
module wdt_reset_pulse (
  // clock and reset
  input  wire sys_clk_i,
  input  wire resetn_i,
  // trigger and output
  input  wire fire_i,
  output reg  active_o
);
  reg [7:0] cnt_q;

  // a fresh trigger during a pulse restarts its length
  always @(posedge sys_clk_i)
  begin
    if (!resetn_i)
    begin
      cnt_q    <= 8'h00;
      active_o <= 1'b0;
    end
    else if (fire_i)
    begin
      cnt_q    <= `WDT_RESET_PULSE_CYC;
      active_o <= 1'b1;
    end
    else if (cnt_q != 8'h00)
    begin
      cnt_q    <= cnt_q - 8'h01;
      active_o <= (cnt_q != 8'h01);
    end
    else
    begin
      active_o <= 1'b0;
    end
  end
endmodule

// ---- tb/wdt_timer_props.sv ----
`timescale 1ns/100ps
module wdt_timer_props (
  // clock and reset
  input wire        sys_clk_i,
  input wire        resetn_i,
  // apb
  input wire        psel_i,
  input wire        penable_i,
  input wire [31:0] prdata_o,
  input wire        pready_o,
  input wire        pslverr_o,
  // events
  input wire        wd_reset_o,
  input wire        reset_pin_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!resetn_i);

  a_ready_single: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  a_ready_timing: assert property (psel_i && $rose(penable_i) |=> pready_o)
    else $error("ready not one cycle after access start");
  a_ready_in_access: assert property (pready_o |-> psel_i && penable_i)
    else $error("ready outside access phase");
  a_error_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("error without ready");
  a_read_upper_zero: assert property (pready_o |-> prdata_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_pin_gated: assert property (reset_pin_o |-> wd_reset_o)
    else $error("pin reset without internal reset");
  a_pulse_length: assert property ($rose(wd_reset_o) |-> wd_reset_o[*8] ##1 wd_reset_o[*8] ##1 !wd_reset_o)
    else $error("reset pulse length wrong");
  a_pin_follows: assert property ($rose(reset_pin_o) |-> $rose(wd_reset_o))
    else $error("pin pulse not aligned");
endmodule

bind wdt_timer wdt_timer_props wdt_timer_props_i (.*);

// ---- tb/wdt_sys_model.sv ----
`timescale 1ns/100ps
// system side: counts reset requests seen by the chip reset logic
module wdt_sys_model (
  // clock
  input  wire sys_clk_i,
  // watched lines
  input  wire wd_reset_i,
  input  wire reset_pin_i,
  // counts
  output int  rst_cnt_o,
  output int  pin_cnt_o
);
  reg wd_q = 1'b0;
  reg pin_q = 1'b0;
  initial rst_cnt_o = 0;
  initial pin_cnt_o = 0;
  always @(posedge sys_clk_i)
  begin
    wd_q <= wd_reset_i;
    pin_q <= reset_pin_i;
    if (wd_reset_i && !wd_q) rst_cnt_o <= rst_cnt_o + 1;
    if (reset_pin_i && !pin_q) pin_cnt_o <= pin_cnt_o + 1;
  end
endmodule

// ---- tb/wdt_timer_tb.sv ----
`timescale 1ns/100ps
module wdt_timer_tb;
  localparam A_CS = 12'h2A0, A_CNT = 12'h2A4, A_RW = 12'h2A8, A_RR = 12'h2AC;
  localparam A_ST = 12'h2E0, A_MK = 12'h2E4;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic        er;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq, wd_rst, rst_pin;
  int          rst_cnt, pin_cnt, errors = 0, comparisons = 0;
  int          dv[8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};

  wdt_timer wdt_timer_i (.sys_clk_i(sys_clk), .resetn_i(resetn), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hF), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .irq_o(irq), .wd_reset_o(wd_rst), .reset_pin_o(rst_pin));
  wdt_sys_model wdt_sys_model_i (.sys_clk_i(sys_clk), .wd_reset_i(wd_rst), .reset_pin_i(rst_pin),
    .rst_cnt_o(rst_cnt), .pin_cnt_o(pin_cnt));

  initial forever #20 sys_clk = ~sys_clk;

  //////////////////////////////////////////////////////////////////
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge sys_clk);
      penable <= 1'b1;
      // no cycle count assumed: only the bench watchdog ends a hung wait
      do
      begin
        @(posedge sys_clk);
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
    end
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task chk_rng(input logic [31:0] got, input int lo, input int hi);
    comparisons++;
    if ($isunknown(got) || got < lo || got > hi)
    begin
      errors++;
      $display("unexpected at %0t: got %h expected %h to %h", $time, got, lo, hi);
    end
  endtask

  task rd_chk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 16'h0000);
    chk(rd, exp);
  endtask

  //////////////////////////////////////////////////////////////////
  task t_reset;
    rd_chk(A_CS, 32'h18);
    rd_chk(A_CNT, 32'h00);
    rd_chk(A_RR, 32'h3F);
    apb(1'b0, 12'hFFC, 16'h0000);
    chk(er, 1'b1);
    $display("test reset done");
  endtask

  // wrong divider shows as a count off by a factor of two or more
  task t_divider;
    for (int c = 0; c < 8; c++)
    begin
      apb(1'b1, A_CS, 16'hA500 | 16'(c));
      rd_chk(A_CNT, 32'h00);
      apb(1'b1, A_CS, 16'hA520 | 16'(c));
      repeat (8 * dv[c]) @(posedge sys_clk);
      apb(1'b0, A_CNT, 16'h0000);
      chk_rng(rd, 7, 11);
    end
    apb(1'b1, A_CS, 16'hA500);
    rd_chk(A_CNT, 32'h00);
    $display("test divider done");
  endtask

  task t_interval;
    apb(1'b1, A_MK, 16'h0000);
    // the counter is held at zero while stopped, so start it before loading it
    apb(1'b1, A_CS, 16'hA520);
    apb(1'b1, A_CS, 16'h5AFE);
    repeat (20) @(posedge sys_clk);
    chk(irq, 1'b0);
    rd_chk(A_CS, 32'hB8);
    apb(1'b1, A_MK, 16'h0001);
    // irq is registered one edge after the mask or status changes
    @(posedge sys_clk);
    chk(irq, 1'b1);
    rd_chk(A_ST, 32'h01);
    @(posedge sys_clk);
    chk(irq, 1'b0);
    apb(1'b1, A_CS, 16'hA5A0);
    rd_chk(A_CS, 32'hB8);
    apb(1'b1, A_CS, 16'hA520);
    rd_chk(A_CS, 32'h38);
    apb(1'b1, A_CS, 16'hA500);
    chk(rst_cnt, 0);
    $display("test interval done");
  endtask

  task t_watchdog;
    apb(1'b1, A_RW, 16'h5A40);
    rd_chk(A_RR, 32'h7F);
    apb(1'b1, A_CS, 16'hA560);
    apb(1'b1, A_CS, 16'h5AFE);
    repeat (60) if (wd_rst !== 1'b1) @(posedge sys_clk);
    apb(1'b1, A_CS, 16'hA500);
    repeat (20) @(posedge sys_clk);
    chk(rst_cnt, 1);
    chk(pin_cnt, 1);
    rd_chk(A_RR, 32'hFF);
    apb(1'b1, A_RW, 16'hA580);
    rd_chk(A_RR, 32'hFF);
    apb(1'b1, A_RW, 16'hA500);
    rd_chk(A_RR, 32'h7F);
    rd_chk(A_ST, 32'h02);
    $display("test watchdog done");
  endtask

  //////////////////////////////////////////////////////////////////
  task print_verdict;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  initial
  begin
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    t_reset();
    t_divider();
    t_interval();
    t_watchdog();
    print_verdict();
  end

  initial
  begin
    // divider test needs about 57500 cycles; this allows 75000
    #3000000;
    errors++;
    print_verdict();
  end
endmodule
